// [rtl/srg_pkg.sv]
// Shared constants and carrier types for the eight-stage shift register block.
package srg_pkg;

    localparam int          STAGE_COUNT    = 8;
    localparam int          WORD_WIDTH     = 32;
    localparam int          ADDR_WIDTH     = 8;
    localparam int          DATA_WIDTH     = 32;

    localparam logic [7:0]  REG_CONFIG     = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_WORD_BASE  = 8'h10;
    localparam logic [7:0]  REG_WORD_LAST  = 8'h2C;

    localparam int          CFG_FORMAT_BIT = 0;
    localparam logic        FORMAT_RESET   = 1'b0;

    localparam int          STS_BITS_LSB   = 0;
    localparam int          STS_FORMAT_BIT = 8;
    localparam int          STS_ENABLE_BIT = 9;
    localparam int          STS_OP_LSB     = 12;

    typedef struct packed {
        logic enable;
        logic fwd_pulse;
        logic bwd_pulse;
        logic clear;
        logic fwd_bit;
        logic bwd_bit;
    } srg_coils_type;

    typedef logic [STAGE_COUNT-1:0][WORD_WIDTH-1:0] srg_words_type;

    typedef enum logic [3:0] {
        SRG_OP_IDLE  = 4'h1,
        SRG_OP_FWD   = 4'h2,
        SRG_OP_BWD   = 4'h4,
        SRG_OP_CLEAR = 4'h8
    } srg_op_type;

endpackage

// [rtl/srg_rise.sv]
// Rising-edge detector for the pulse coils.
`timescale 1ns/1ps
module srg_rise #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] rise_o
);
    import srg_pkg::*;

    logic [WIDTH-1:0] prev;

    // The previous level is tracked even while the block is disabled, so a coil
    // that is already high when the enable arrives does not count as a new pulse.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev <= '0;
        end else if (ce_i) begin
            prev <= level_i;
        end
    end

    assign rise_o = level_i & ~prev;

endmodule

// [rtl/srg_stages.sv]
// Linear, non-circulating shift stage array with forward and backward loading.
`timescale 1ns/1ps
module srg_stages #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32
) (
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        ce_i,
    input  wire logic                        clear_i,
    input  wire logic                        shift_fwd_i,
    input  wire logic                        shift_bwd_i,
    input  wire logic [WIDTH-1:0]            fwd_in_i,
    input  wire logic [WIDTH-1:0]            bwd_in_i,
    output logic      [DEPTH-1:0][WIDTH-1:0] stage_o
);
    import srg_pkg::*;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            logic [WIDTH-1:0] fwd_src;
            logic [WIDTH-1:0] bwd_src;
            // The end stages take the new entry; the far end simply drops its content.
            if (i == 0) begin : g_first
                assign fwd_src = fwd_in_i;
            end else begin : g_fwd_mid
                assign fwd_src = stage_o[i-1];
            end
            if (i == DEPTH - 1) begin : g_last
                assign bwd_src = bwd_in_i;
            end else begin : g_bwd_mid
                assign bwd_src = stage_o[i+1];
            end
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    stage_o[i] <= '0;
                end else if (ce_i) begin
                    if (clear_i) begin
                        stage_o[i] <= '0;
                    end else if (shift_fwd_i) begin
                        stage_o[i] <= fwd_src;
                    end else if (shift_bwd_i) begin
                        stage_o[i] <= bwd_src;
                    end
                end
            end
        end
    endgenerate

endmodule

// [rtl/srg_top.sv]
// Top of the eight-stage bidirectional shift register with bit and word formats.
//
// What this block does
// - No stage action happens while the enable coil is off.
// - Bit format: forward pulse loads forward bit.
// - Word format: forward pulse loads forward value.
// - Forward pulse moves stages toward stage eight.
// - Bit format: backward pulse loads stage eight.
// - Word format: backward pulse loads word stage eight.
// - Backward pulse moves stages toward stage one.
// - Far-end entry is dropped, never recirculated.
// - Clear zeroes every stage in both formats.
// - Two formats: bit stages or word stages.
// - Word stages hold signed 32-bit values.
// - Bit format: contact closed while stage holds one.
// - Word outputs show stages only in word format.
// - Bit format ignores value inputs and outputs.
// - Format defaults to bit after reset.
`timescale 1ns/1ps
module srg_top (
    input  wire logic                              CLK_I,
    input  wire logic                              RESET_N_I,
    input  wire logic                              CE_I,
    input  wire srg_pkg::srg_coils_type            COILS_I,
    input  wire logic signed [srg_pkg::WORD_WIDTH-1:0] FORWARD_VALUE_IN_I,
    input  wire logic signed [srg_pkg::WORD_WIDTH-1:0] BACKWARD_VALUE_IN_I,
    input  wire logic [srg_pkg::ADDR_WIDTH-1:0]    ADDR_I,
    input  wire logic [srg_pkg::DATA_WIDTH-1:0]    WDATA_I,
    input  wire logic                              WR_I,
    input  wire logic                              RD_I,
    output logic      [srg_pkg::DATA_WIDTH-1:0]    RDATA_O,
    output logic      [srg_pkg::STAGE_COUNT-1:0]   BIT_STAGE_CONTACTS_O,
    output srg_pkg::srg_words_type                 WORD_STAGE_OUTPUTS_O
);
    import srg_pkg::*;

    logic                                 double_word_format;
    logic [1:0]                           pulse_rise;
    logic                                 fwd_rise;
    logic                                 bwd_rise;
    logic                                 do_clear;
    logic                                 do_fwd;
    logic                                 do_bwd;
    logic                                 bit_fwd;
    logic                                 bit_bwd;
    logic                                 word_fwd;
    logic                                 word_bwd;
    logic [STAGE_COUNT-1:0][0:0]          bit_stage;
    srg_words_type                        word_stage;
    srg_op_type                           op;
    srg_op_type                           next_op;
    logic [2:0]                           word_index;
    logic [ADDR_WIDTH-1:0]                word_offset;
    logic [DATA_WIDTH-1:0]                next_rdata;

    srg_rise #(
        .WIDTH (2)
    ) u_rise (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .ce_i      (CE_I),
        .level_i   ({COILS_I.bwd_pulse, COILS_I.fwd_pulse}),
        .rise_o    (pulse_rise)
    );

    assign fwd_rise = pulse_rise[0];
    assign bwd_rise = pulse_rise[1];

    // Clear is a level, so it keeps the stages at zero for as long as it is held.
    assign do_clear = COILS_I.enable & COILS_I.clear;
    assign do_fwd   = COILS_I.enable & ~COILS_I.clear & fwd_rise & ~bwd_rise;
    assign do_bwd   = COILS_I.enable & ~COILS_I.clear & bwd_rise & ~fwd_rise;

    // Only the register of the selected format moves; the other keeps its content.
    assign bit_fwd  = do_fwd & ~double_word_format;
    assign bit_bwd  = do_bwd & ~double_word_format;
    assign word_fwd = do_fwd & double_word_format;
    assign word_bwd = do_bwd & double_word_format;

    // Stage one is index zero.
    srg_stages #(
        .DEPTH (STAGE_COUNT),
        .WIDTH (1)
    ) u_bits (
        .clk_i       (CLK_I),
        .reset_n_i   (RESET_N_I),
        .ce_i        (CE_I),
        .clear_i     (do_clear),
        .shift_fwd_i (bit_fwd),
        .shift_bwd_i (bit_bwd),
        .fwd_in_i    (COILS_I.fwd_bit),
        .bwd_in_i    (COILS_I.bwd_bit),
        .stage_o     (bit_stage)
    );

    srg_stages #(
        .DEPTH (STAGE_COUNT),
        .WIDTH (WORD_WIDTH)
    ) u_words (
        .clk_i       (CLK_I),
        .reset_n_i   (RESET_N_I),
        .ce_i        (CE_I),
        .clear_i     (do_clear),
        .shift_fwd_i (word_fwd),
        .shift_bwd_i (word_bwd),
        .fwd_in_i    (FORWARD_VALUE_IN_I),
        .bwd_in_i    (BACKWARD_VALUE_IN_I),
        .stage_o     (word_stage)
    );

    assign BIT_STAGE_CONTACTS_O = double_word_format ? '0 : bit_stage;
    assign WORD_STAGE_OUTPUTS_O = double_word_format ? word_stage : '0;

    // Format selection; changing it leaves both stage registers untouched.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            double_word_format <= FORMAT_RESET;
        end else if (CE_I && WR_I && ADDR_I == REG_CONFIG) begin
            double_word_format <= WDATA_I[CFG_FORMAT_BIT];
        end
    end

    always_comb begin
        next_op = SRG_OP_IDLE;
        if (do_clear) begin
            next_op = SRG_OP_CLEAR;
        end else if (do_fwd) begin
            next_op = SRG_OP_FWD;
        end else if (do_bwd) begin
            next_op = SRG_OP_BWD;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            op <= SRG_OP_IDLE;
        end else if (CE_I) begin
            case (op)
                SRG_OP_IDLE:  op <= next_op;
                SRG_OP_FWD:   op <= next_op;
                SRG_OP_BWD:   op <= next_op;
                SRG_OP_CLEAR: op <= next_op;
                default:      op <= SRG_OP_IDLE;
            endcase
        end
    end

    // The word window does not start at zero, so the index is taken from the offset to its base.
    assign word_offset = ADDR_I - REG_WORD_BASE;
    assign word_index  = word_offset[4:2];

    always_comb begin
        next_rdata = '0;
        if (!RD_I) begin
            next_rdata = '0;
        end else if (ADDR_I == REG_CONFIG) begin
            next_rdata[CFG_FORMAT_BIT] = double_word_format;
        end else if (ADDR_I == REG_STATUS) begin
            next_rdata[STS_BITS_LSB +: STAGE_COUNT] = bit_stage;
            next_rdata[STS_FORMAT_BIT]              = double_word_format;
            next_rdata[STS_ENABLE_BIT]              = COILS_I.enable;
            next_rdata[STS_OP_LSB +: 4]             = op;
        end else if (ADDR_I >= REG_WORD_BASE && ADDR_I <= REG_WORD_LAST && ADDR_I[1:0] == 2'h0) begin
            next_rdata = word_stage[word_index];
        end
    end

    // Read data follow the strobe by one cycle and return to zero on the first enabled cycle without it; they hold while CE_I is low.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= '0;
        end else if (CE_I) begin
            RDATA_O <= next_rdata;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_fwd_bit_load: assert property (CE_I && bit_fwd |=> bit_stage[0] == $past(COILS_I.fwd_bit))
        else $error("Forward pulse did not load the forward bit into stage one.");

    a_fwd_bit_move: assert property (CE_I && bit_fwd |=> bit_stage[7:1] == $past(bit_stage[6:0]))
        else $error("Forward pulse did not move bit stages up by one.");

    a_fwd_word_load: assert property (CE_I && word_fwd |=> word_stage[0] == $past(FORWARD_VALUE_IN_I)
                                      && word_stage[7:1] == $past(word_stage[6:0]))
        else $error("Forward pulse did not load and move the word stages.");

    a_bwd_bit_load: assert property (CE_I && bit_bwd |=> bit_stage[7] == $past(COILS_I.bwd_bit)
                                     && bit_stage[6:0] == $past(bit_stage[7:1]))
        else $error("Backward pulse did not load and move the bit stages.");

    a_bwd_word_move: assert property (CE_I && word_bwd |=> word_stage[7] == $past(BACKWARD_VALUE_IN_I)
                                      && word_stage[6:0] == $past(word_stage[7:1]))
        else $error("Backward pulse did not load and move the word stages.");

    a_clear_zero: assert property (CE_I && COILS_I.enable && COILS_I.clear
                                   |=> bit_stage == '0 && word_stage == '0)
        else $error("Clear did not zero every stage.");

    a_disabled_hold: assert property (CE_I && !COILS_I.enable
                                      |=> $stable(bit_stage) && $stable(word_stage))
        else $error("Stages changed while the block was disabled.");

    // A clear that arrives with both pulses still wins, so only pulse pairs without clear must leave the stages.
    a_dual_ignored: assert property (CE_I && fwd_rise && bwd_rise && !COILS_I.clear
                                     |=> $stable(bit_stage) && $stable(word_stage))
        else $error("Simultaneous pulses changed the stages.");

    a_bit_mode_quiet: assert property (!double_word_format
                                       |-> WORD_STAGE_OUTPUTS_O == '0 && BIT_STAGE_CONTACTS_O == bit_stage)
        else $error("Outputs do not follow the bit format.");

    a_single_shift: assert property (CE_I && do_fwd ##1 CE_I && COILS_I.fwd_pulse && !COILS_I.clear
                                     && !bwd_rise |=> $stable(bit_stage) && $stable(word_stage))
        else $error("A held pulse coil caused a second shift.");

    a_enable_gate: assert property (!COILS_I.enable |-> !do_clear && !do_fwd && !do_bwd)
        else $error("An action was taken while the enable coil was off.");

    a_action_onehot: assert property ($onehot0({do_clear, do_fwd, do_bwd}))
        else $error("More than one stage action was requested at once.");

    a_words_bit_mode: assert property (CE_I && !double_word_format && !do_clear |=> $stable(word_stage))
        else $error("Word stages moved in bit format.");

    a_bits_word_mode: assert property (CE_I && double_word_format && !do_clear |=> $stable(bit_stage))
        else $error("Bit stages moved in double-word format.");

    a_word_mode_out: assert property (double_word_format
                                      |-> WORD_STAGE_OUTPUTS_O == word_stage && BIT_STAGE_CONTACTS_O == '0)
        else $error("Outputs do not follow the double-word format.");

    a_freeze_ce: assert property (!CE_I |=> $stable(bit_stage) && $stable(word_stage)
                                  && $stable(double_word_format) && $stable(RDATA_O))
        else $error("State changed while the clock enable was low.");

    a_read_idle: assert property (CE_I && !RD_I |=> RDATA_O == '0)
        else $error("Read data stood outside the cycle after a read.");

    a_config_read: assert property (CE_I && RD_I && ADDR_I == REG_CONFIG
                                    |=> RDATA_O[CFG_FORMAT_BIT] == $past(double_word_format))
        else $error("Configuration read did not return the format.");

    c_fwd_word: cover property (CE_I && word_fwd);
    c_bwd_bit: cover property (CE_I && bit_bwd);
    c_clear: cover property (CE_I && do_clear ##1 CE_I && bit_fwd);
    c_dual: cover property (CE_I && COILS_I.enable && fwd_rise && bwd_rise);

endmodule

// [tb/srg_coil_drv.sv]
// Model of the controlling logic that turns bench requests into coil levels.
`timescale 1ns/1ps
module srg_coil_drv (
    input  wire logic             clk_i,
    input  wire logic             en_i,
    input  wire logic [2:0]       req_i,
    input  wire logic             fbit_i,
    input  wire logic             bbit_i,
    output srg_pkg::srg_coils_type coils_o
);
    import srg_pkg::*;
    // A coil stands as long as its request does; requests last one or two cycles, so a pulse drops before it re-arms.
    always_ff @(posedge clk_i) begin
        coils_o.enable    <= en_i;
        coils_o.fwd_pulse <= req_i[0];
        coils_o.bwd_pulse <= req_i[1];
        coils_o.clear     <= req_i[2];
        // Data bits toggle when unused, so a stale level is never mistaken for real data.
        coils_o.fwd_bit   <= req_i[0] ? fbit_i : ~coils_o.fwd_bit;
        coils_o.bwd_bit   <= req_i[1] ? bbit_i : ~coils_o.bwd_bit;
    end
endmodule

// [tb/testbench.sv]
// Self-checking bench: random coil and bus traffic compared against a reference model.
`timescale 1ns/1ps
module testbench;
    import srg_pkg::*;
    logic               clk, rst_n, ce, en, fb, bb, wr, rd;
    logic [2:0]         req;
    logic signed [31:0] fv, bv;
    logic [7:0]         addr, bitm;
    logic [31:0]        wdata, rdata;
    logic [31:0]        wordm [8];
    logic [7:0]         contacts;
    srg_words_type      words;
    srg_coils_type      coils;
    logic               fmt;
    int                 fail_count, checks_done, seed, k, p;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    srg_coil_drv u_drv (.clk_i(clk), .en_i(en), .req_i(req), .fbit_i(fb), .bbit_i(bb), .coils_o(coils));

    srg_top u_dut (
        .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .COILS_I(coils),
        .FORWARD_VALUE_IN_I(fv), .BACKWARD_VALUE_IN_I(bv),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .BIT_STAGE_CONTACTS_O(contacts), .WORD_STAGE_OUTPUTS_O(words)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, exp);
    endtask

    // One coil action, sometimes held a second cycle; the model then predicts both stage arrays.
    task automatic step(input logic e, input logic [2:0] r);
        int   n;
        logic act;
        @(posedge clk);
        n = $random(seed);
        act = e && ce;
        en <= e;
        req <= r;
        fb <= 1'($random(seed));
        bb <= 1'($random(seed));
        fv <= (n[9:8] == 2'h0) ? 32'h80000000 : $random(seed);
        bv <= (n[9:8] == 2'h1) ? 32'h7FFFFFFF : $random(seed);
        @(posedge clk);
        if (!n[10]) begin
            req <= 3'h0;
        end
        @(posedge clk);
        req <= 3'h0;
        #1;
        if (act && r[2]) begin
            bitm = 8'h00;
            for (n = 0; n < 8; n++) wordm[n] = 32'h0;
        end else if (act && r[0] && !r[1]) begin
            if (fmt) begin
                for (n = 7; n > 0; n--) wordm[n] = wordm[n-1];
                wordm[0] = fv;
            end else begin
                bitm = {bitm[6:0], fb};
            end
        end else if (act && r[1] && !r[0]) begin
            if (fmt) begin
                for (n = 0; n < 7; n++) wordm[n] = wordm[n+1];
                wordm[7] = bv;
            end else begin
                bitm = {bb, bitm[7:1]};
            end
        end
        chk({24'h0, contacts}, fmt ? 32'h0 : {24'h0, bitm});
        for (n = 0; n < 8; n++) chk(words[n], fmt ? wordm[n] : 32'h0);
    endtask

    initial begin
        seed = 76;
        fail_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        {en, fb, bb, wr, rd, req, fv, bv, addr, wdata, fmt, bitm} = '0;
        for (k = 0; k < 8; k++) wordm[k] = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(REG_CONFIG, 32'h1, 32'h0);
        for (p = 0; p < 2; p++) begin
            if (p == 1) begin
                bus_wr(REG_CONFIG, 32'h1);
                fmt = 1'b1;
            end
            repeat (80) begin
                k = $random(seed);
                step(k[4:3] != 2'h0, {k[7:5] == 3'h0, k[1:0]});
            end
            // With the clock enable low every action must be lost; one spare edge lets a held coil drop first.
            ce <= 1'b0;
            repeat (4) begin
                k = $random(seed);
                step(1'b1, k[2:0]);
            end
            @(posedge clk);
            ce <= 1'b1;
            bus_wr(REG_STATUS, $random(seed));
            bus_wr(8'h08, $random(seed));
            rd_chk(8'h08, 32'hFFFFFFFF, 32'h0);
            rd_chk(REG_STATUS, 32'hF3FF, {16'h0, 4'h1, 2'h0, en, fmt, bitm});
            for (k = 0; k < 8; k++) rd_chk(REG_WORD_BASE + 8'(4 * k), 32'hFFFFFFFF, wordm[k]);
        end
        // A reset in mid-run must bring back bit format and empty stages.
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        {fmt, bitm} = '0;
        for (k = 0; k < 8; k++) wordm[k] = 32'h0;
        rd_chk(REG_CONFIG, 32'h1, 32'h0);
        step(1'b1, 3'h1);
        stop_test();
    end

    // Far longer than the whole sequence needs, so only a hang gets here first.
    initial begin
        #(8 * 20000);
        fail_count++;
        stop_test();
    end
endmodule
